/* core/sbrg_map.vh */
// Constants of the serial baud rate generator: register indices,
// field positions, reset values and division factors.
// Assumes inclusion by name from the design file only.
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// ============================================================
// Register indices on the plain register port
`define SBRG_ADDR_W 3
`define SBRG_IDX_DIV_LOW 3'h0
`define SBRG_IDX_DIV_HIGH 3'h1
`define SBRG_IDX_TX_CTRL 3'h2
`define SBRG_IDX_BAUD_CTRL 3'h3
`define SBRG_IDX_CNT_LOW 3'h4
`define SBRG_IDX_CNT_HIGH 3'h5

// ============================================================
// Field positions
`define SBRG_BIT_SYNC 4
`define SBRG_BIT_HIGH_SPEED 2
`define SBRG_BIT_WIDE 3

// ============================================================
// Reset values and access masks
`define SBRG_RST_DIV 8'h00
`define SBRG_RST_TX_CTRL 8'h00
`define SBRG_RST_BAUD_CTRL 8'h00
`define SBRG_TX_CTRL_WMASK 8'hfd
`define SBRG_TX_CTRL_RONE 8'h02
`define SBRG_BAUD_CTRL_WMASK 8'h1b
`define SBRG_BAUD_CTRL_RONE 8'h40

// ============================================================
// Prescale factors minus one, applied ahead of the n+1 divider
`define SBRG_DIV_ASYNC_LOW 6'h3f
`define SBRG_DIV_ASYNC_MID 6'h0f
`define SBRG_DIV_FAST 6'h03

`endif

/* core/sbrg_top.v */
// Baud rate generator of the serial port: divisor and mode registers
// and a programmable divider producing one tick per bit time.
// Assumes a same-clock register master; strobes never overlap.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none
`include "sbrg_map.vh"

module sbrg_top (
    // Clock, reset and enable
    input wire sys_clk_i,
    input wire rst_i,
    input wire clk_en_i,

    // Register port
    input wire [`SBRG_ADDR_W-1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,

    // Timing outputs
    output reg baud_tick_o,
    output reg sync_mode_o
);

    // ============================================================
    // Register state
    reg [7:0] div_low_reg;
    reg [7:0] div_high_reg;
    reg [7:0] tx_ctrl_reg;
    reg [7:0] baud_ctrl_reg;

    // ============================================================
    // Divider state
    reg [5:0] pre_reg;
    reg [5:0] pre_next;
    reg [15:0] cnt_reg;
    reg [15:0] cnt_next;
    reg tick_next;

    // ============================================================
    // Decoded controls
    wire wr_low;
    wire wr_high;
    wire wr_tx;
    wire wr_baud;
    wire restart;
    wire mode_sync;
    wire mode_wide;
    wire mode_fast;
    reg [5:0] pre_last;
    reg [15:0] divisor;
    reg [7:0] rdata_next;
    reg [7:0] low_in;
    reg [7:0] high_in;

    assign wr_low = reg_wr_i && (reg_addr_i == `SBRG_IDX_DIV_LOW);
    assign wr_high = reg_wr_i && (reg_addr_i == `SBRG_IDX_DIV_HIGH);
    assign wr_tx = reg_wr_i && (reg_addr_i == `SBRG_IDX_TX_CTRL);
    assign wr_baud = reg_wr_i && (reg_addr_i == `SBRG_IDX_BAUD_CTRL);

    // Either divisor byte restarts the count
    assign restart = wr_low || wr_high;

    assign mode_sync = tx_ctrl_reg[`SBRG_BIT_SYNC];
    assign mode_wide = baud_ctrl_reg[`SBRG_BIT_WIDE];
    assign mode_fast = tx_ctrl_reg[`SBRG_BIT_HIGH_SPEED];

    // ============================================================
    // Divisor as it stands after this cycle's write
    always @* begin
        low_in = div_low_reg;
        high_in = div_high_reg;
        if (wr_low) begin
            low_in = reg_wdata_i;
        end
        if (wr_high) begin
            high_in = reg_wdata_i;
        end
        if (mode_wide) begin
            divisor = {high_in, low_in};
        end else begin
            divisor = {8'h00, low_in};
        end
    end

    // ============================================================
    // Prescale factor minus one, chosen by mode
    always @* begin
        if (mode_sync) begin
            pre_last = `SBRG_DIV_FAST;
        end else if (!mode_wide && !mode_fast) begin
            pre_last = `SBRG_DIV_ASYNC_LOW;
        end else if (mode_wide && mode_fast) begin
            pre_last = `SBRG_DIV_FAST;
        end else begin
            pre_last = `SBRG_DIV_ASYNC_MID;
        end
    end

    // ============================================================
    // Divider: prescaler then n+1 down counter, period P*(n+1)
    always @* begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (restart) begin
            pre_next = 6'h00;
            cnt_next = divisor;
        end else if (pre_reg >= pre_last) begin
            // A mode change can leave the prescaler beyond its new end
            pre_next = 6'h00;
            if (cnt_reg == 16'h0000) begin
                cnt_next = divisor;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else begin
            pre_next = pre_reg + 6'h01;
        end
    end

    // ============================================================
    // Read mux: unmapped indices read zero
    always @* begin
        case (reg_addr_i)
            `SBRG_IDX_DIV_LOW: begin
                rdata_next = div_low_reg;
            end
            `SBRG_IDX_DIV_HIGH: begin
                rdata_next = div_high_reg;
            end
            `SBRG_IDX_TX_CTRL: begin
                rdata_next = tx_ctrl_reg | `SBRG_TX_CTRL_RONE;
            end
            `SBRG_IDX_BAUD_CTRL: begin
                rdata_next = baud_ctrl_reg | `SBRG_BAUD_CTRL_RONE;
            end
            `SBRG_IDX_CNT_LOW: begin
                rdata_next = cnt_reg[7:0];
            end
            `SBRG_IDX_CNT_HIGH: begin
                rdata_next = cnt_reg[15:8];
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // ============================================================
    // Registers
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_low_reg <= `SBRG_RST_DIV;
            div_high_reg <= `SBRG_RST_DIV;
            tx_ctrl_reg <= `SBRG_RST_TX_CTRL;
            baud_ctrl_reg <= `SBRG_RST_BAUD_CTRL;
        end else if (clk_en_i) begin
            if (wr_low) begin
                div_low_reg <= reg_wdata_i;
            end
            if (wr_high) begin
                div_high_reg <= reg_wdata_i;
            end
            if (wr_tx) begin
                tx_ctrl_reg <= reg_wdata_i & `SBRG_TX_CTRL_WMASK;
            end
            if (wr_baud) begin
                baud_ctrl_reg <= reg_wdata_i & `SBRG_BAUD_CTRL_WMASK;
            end
        end
    end

    // ============================================================
    // Divider and outputs
    // The enable freezes the tick too, so a pulse lasts while it is low
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= 6'h00;
            cnt_reg <= 16'h0000;
            baud_tick_o <= 1'b0;
            sync_mode_o <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            baud_tick_o <= tick_next;
            sync_mode_o <= mode_sync;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_next;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

/* sim/sbrg_chk_sva.sv */
// Port-level checker for the baud rate generator.
// Assumes the clock enable is held high by the surroundings.
`timescale 1ns/1ps
`default_nettype none
module sbrg_chk (
    // Clock, reset and enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Timing outputs
    input wire logic baud_tick_o,
    input wire logic sync_mode_o
);
    // ==========
    // Properties
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_tx_wr;
        reg_wr_i && reg_addr_i == 3'h2;
    endsequence
    // Shortest legal period is four clocks
    sequence s_quiet;
        !baud_tick_o [*3];
    endsequence
    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not idle");
    AST_TICK_GAP: assert property (baud_tick_o |=> s_quiet)
        else $error("ticks too close");
    AST_RESTART_LOW: assert property (reg_wr_i && reg_addr_i == 3'h0 |=> s_quiet)
        else $error("tick soon after low write");
    AST_RESTART_HIGH: assert property (reg_wr_i && reg_addr_i == 3'h1 |=> s_quiet)
        else $error("tick soon after high write");
    AST_SYNC_COPY: assert property (s_tx_wr |=> ##1 sync_mode_o == $past(reg_wdata_i[4], 2))
        else $error("sync output wrong");
    AST_SYNC_HOLD: assert property ($changed(sync_mode_o) |-> $past(reg_wr_i && reg_addr_i == 3'h2, 2))
        else $error("sync output moved");
    AST_TRMT_ONE: assert property (reg_rd_i && reg_addr_i == 3'h2 |=> reg_rdata_o[1])
        else $error("status bit low");
    AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind sbrg_top sbrg_chk u_chk (.*);
`default_nettype wire

/* sim/sbrg_tb.sv */
// Self-checking bench for the baud rate generator.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    wire logic [7:0] reg_rdata_o;
    wire logic baud_tick_o;
    wire logic sync_mode_o;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // ==========
    // Rows: tx ctrl, baud ctrl, low, high, period
    logic [47:0] tv [9] = '{48'h0000_0200_00c0, 48'h0400_0300_0040, 48'h0008_0101_1020,
        48'h0408_0500_0018, 48'h1000_0400_0014, 48'h1400_0400_0014,
        48'h1008_0201_040c, 48'h0000_0105_0080, 48'h1000_0003_0004};
    sbrg_top uut (.*);
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles > 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask
    // Two periods: from the restart, then tick to tick
    task meas(input logic [15:0] e);
        logic [15:0] c;
        for (int k = 0; k < 2; k++) begin
            c = 16'h0000;
            do begin
                @(posedge sys_clk_i);
                #1;
                c++;
            end while (baud_tick_o !== 1'b1 && c < 16'h2400);
            chk(c, e);
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            wr(3'h2, tv[i][47:40]);
            wr(3'h3, tv[i][39:32]);
            wr(3'h1, tv[i][23:16]);
            wr(3'h0, tv[i][31:24]);
            meas(tv[i][15:0]);
            rd(3'h0, tv[i][31:24]);
            rd(3'h1, tv[i][23:16]);
        end
        // Rewrite mid-period; a missed restart ticks 18 clocks after the write, 22 clocks early
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h09);
        for (int k = 0; k < 2; k++) begin
            repeat (20) @(posedge sys_clk_i);
            wr(k[2:0], k ? 8'h00 : 8'h09);
            meas(16'd40);
        end
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h02);
        rd(3'h3, 8'h40);
        rd(3'h7, 8'h00);
        wr(3'h0, 8'h00);
        meas(16'd64);
        // Ten frozen edges right after a restart must stretch the first period
        wr(3'h0, 8'h00);
        clk_en_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
        meas(16'd64);
        // The live counter holds the freshly loaded divisor after a restart
        wr(3'h3, 8'h08);
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h5, 8'h01);
        rd(3'h4, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
